//--- umc_consts.svh
// Constants for the first mode register block: fields, resets, commands
`ifndef UMC_CONSTS_SVH
`define UMC_CONSTS_SVH

// ----------------------------------------------------------------------
// Bus offsets (byte addresses within the channel)
// ----------------------------------------------------------------------
`define UMC_OFS_MODE     4'h0
`define UMC_OFS_COMMAND  4'h8

// ----------------------------------------------------------------------
// First mode register fields, plus the transmit RTS bit of the second register
// ----------------------------------------------------------------------
`define UMC_BIT_RXFLOW   7
`define UMC_BIT_IRQSEL   6
`define UMC_BIT_ERRMODE  5
`define UMC_PM_HI        4
`define UMC_PM_LO        3
`define UMC_BIT_PTYPE    2
`define UMC_BPC_HI       1
`define UMC_BPC_LO       0
`define UMC_BIT_TXFLOW   5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UMC_MODE1_RST    8'h00
`define UMC_MODE2_RST    8'h00

// ----------------------------------------------------------------------
// Command register miscellaneous field and its codes
// ----------------------------------------------------------------------
`define UMC_MISC_HI      6
`define UMC_MISC_LO      4
`define UMC_CMD_RSTPTR   3'h1
`define UMC_CMD_RSTERR   3'h4

`endif

//--- umc_pkg.sv
// Types shared by the first mode register block
`default_nettype none

package umc_pkg;
    // Parity mode field encodings
    typedef enum logic [1:0] {
        UMC_PM_WITH  = 2'h0,
        UMC_PM_FORCE = 2'h1,
        UMC_PM_NONE  = 2'h2,
        UMC_PM_MDROP = 2'h3
    } umc_pmode_t;

    // Pointer state between the two mode registers
    typedef enum logic {
        UMC_PTR_FIRST,
        UMC_PTR_SECOND
    } umc_ptr_t;
endpackage : umc_pkg

`default_nettype wire

//--- umc_rts_ctrl.sv
// Receiver-side request-to-send flow control
`default_nettype none

module umc_rts_ctrl (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Settings
    input  wire logic rxFlowEn,
    input  wire logic txFlowEn,
    // Receiver events
    input  wire logic startBitValid,
    input  wire logic fifoFull,
    // Result
    output logic      rtsNegate
);
    import umc_pkg::*;

    logic active;

    // Both sides asking for control cancels it for both
    assign active = rxFlowEn & ~txFlowEn;

    // ------------------------------------------------------------------
    // Hold state
    // ------------------------------------------------------------------
    // negate then reassert
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rtsNegate <= 1'b0;
        end else if (!active) begin
            rtsNegate <= 1'b0;
        end else if (startBitValid && fifoFull) begin
            rtsNegate <= 1'b1;
        end else if (!fifoFull) begin
            rtsNegate <= 1'b0;
        end
    end

    AST_RTS_NEG: assert property (@(posedge ref_clk) disable iff (!rst_b)
        active && startBitValid && fifoFull |=> rtsNegate)
        else $error("rts not negated on full fifo");
    AST_RTS_BOTH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rxFlowEn && txFlowEn |=> !rtsNegate)
        else $error("rts control active with both sides enabled");
    AST_RTS_FREE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !fifoFull |=> !rtsNegate)
        else $error("rts held with a free fifo slot");
    COV_RTS: cover property (@(posedge ref_clk) disable iff (!rst_b)
        rtsNegate ##1 !rtsNegate);
endmodule : umc_rts_ctrl

`default_nettype wire

//--- umc_err_status.sv
// Character or block accumulation of receive error flags
`default_nettype none

module umc_err_status (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Control
    input  wire logic       blockMode,
    input  wire logic       resetErr,
    // Status of the character at the FIFO top
    input  wire logic       topValid,
    input  wire logic       topPop,
    input  wire logic [2:0] topErr,
    // Reported break, framing, parity flags
    output logic      [2:0] errFlags
);
    import umc_pkg::*;

    logic [2:0] accum;

    // ------------------------------------------------------------------
    // Block accumulation; new arrivals win over the reset command
    // ------------------------------------------------------------------
    // OR over characters
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            accum <= 3'h0;
        end else if (topValid && topPop) begin
            accum <= (resetErr ? 3'h0 : accum) | topErr;
        end else if (resetErr) begin
            accum <= 3'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            errFlags <= 3'h0;
        end else if (blockMode) begin
            errFlags <= accum | (topValid ? topErr : 3'h0);
        end else begin
            errFlags <= topValid ? topErr : 3'h0;
        end
    end

    AST_ERR_CHAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !blockMode && topValid |=> errFlags == $past(topErr))
        else $error("character mode flags differ from top entry");
    AST_ERR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        blockMode && !resetErr && topValid && topPop ##1 blockMode
        |=> (errFlags & $past(topErr, 2)) == $past(topErr, 2))
        else $error("block mode lost an error");
    COV_ERR_BLOCK: cover property (@(posedge ref_clk) disable iff (!rst_b)
        blockMode && topPop && topErr != 3'h0);
endmodule : umc_err_status

`default_nettype wire

//--- umc_mode_one.sv
// First mode register of a UART channel with pointer and derived controls
`default_nettype none
`include "umc_consts.svh"

// Behaviour
// - The first mode register is reached only while the pointer selects it, as after reset.
// - A reset-pointer command in the command register points back to the first register.
// - Any read or write of the first register moves the pointer to the second register.
// - With bit 7 set, RTS is negated on a valid start bit with a full FIFO and reasserted later.
// - Receiver and transmitter RTS control both enabled disables RTS control for both.
// - Bit 6 picks receiver-ready (0) or FIFO-full (1) as the receiver interrupt source.
// - With bit 5 clear the break, framing and parity flags show the FIFO top character only.
// - With bit 5 set those flags accumulate as an OR until a reset-error command.
// - Bits 4-3 govern transmit parity generation and receive parity checking.
// - Mode 00 even/odd by type bit, 01 forced low/high, 10 no parity bit.
// - Mode 11 marks a data (type 0) or address (type 1) character in the parity slot.
// - Accesses to the second register leave the pointer where it is.
module umc_mode_one (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Byte-wide processor register port
    input  wire logic [3:0]  regAddr,
    input  wire logic        regRd,
    input  wire logic        regWr,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    // Receiver state
    input  wire logic        rxCharAvail,
    input  wire logic        rxFifoFull,
    input  wire logic        startBitValid,
    input  wire logic        topValid,
    input  wire logic        topPop,
    input  wire logic [2:0]  topErr,
    // Transmit parity request
    input  wire logic [7:0]  txData,
    // Outputs to the serial logic
    output logic             rxIrqSrc,
    output logic             rtsNegate,
    output logic      [2:0]  errFlags,
    output logic             txParityEn,
    output logic             txParityBit,
    output logic      [3:0]  dataBits,
    output logic             rxParityChk,
    output logic      [7:0]  modeSecond,
    output umc_pkg::umc_ptr_t modePtr
);
    import umc_pkg::*;

    logic [7:0]  uart_mode_first;
    logic        modeAccess;
    logic        cmdWrite;
    logic        resetPtr;
    logic        resetErr;
    logic [7:0]  maskedData;
    umc_pmode_t  pmode;
    logic        ptype;
    logic        evenPar;
    logic        next_parBit;
    logic        next_parEn;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    // Reads move the pointer as well, so polling offset 0 changes
    // which mode register the following access reaches
    assign modeAccess = (regRd | regWr) && (regAddr == `UMC_OFS_MODE);
    assign cmdWrite   = regWr && (regAddr == `UMC_OFS_COMMAND);
    assign resetPtr   = cmdWrite &&
        (regWdata[`UMC_MISC_HI:`UMC_MISC_LO] == `UMC_CMD_RSTPTR);
    assign resetErr   = cmdWrite &&
        (regWdata[`UMC_MISC_HI:`UMC_MISC_LO] == `UMC_CMD_RSTERR);

    // ------------------------------------------------------------------
    // Mode register pointer
    // ------------------------------------------------------------------
    // reset-pointer command, advance after first access
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            modePtr <= UMC_PTR_FIRST;
        end else if (resetPtr) begin
            modePtr <= UMC_PTR_FIRST;
        end else begin
            case (modePtr)
                UMC_PTR_FIRST: begin
                    if (modeAccess) begin
                        modePtr <= UMC_PTR_SECOND;
                    end
                end
                UMC_PTR_SECOND: begin
                    modePtr <= UMC_PTR_SECOND;
                end
                default: begin
                    modePtr <= UMC_PTR_FIRST;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // write only while selected
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            uart_mode_first <= `UMC_MODE1_RST;
        end else if (regWr && modeAccess && modePtr == UMC_PTR_FIRST) begin
            uart_mode_first <= regWdata;
        end
    end

    // Second register held here so the pointer steering is complete
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            modeSecond <= `UMC_MODE2_RST;
        end else if (regWr && modeAccess && modePtr == UMC_PTR_SECOND) begin
            modeSecond <= regWdata;
        end
    end

    // read data by pointer; other offsets read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else if (regRd && modeAccess) begin
            regRdata <= (modePtr == UMC_PTR_FIRST) ? uart_mode_first : modeSecond;
        end else if (regRd) begin
            regRdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Receiver interrupt source
    // ------------------------------------------------------------------
    // ready or full
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rxIrqSrc <= 1'b0;
        end else begin
            rxIrqSrc <= uart_mode_first[`UMC_BIT_IRQSEL] ? rxFifoFull : rxCharAvail;
        end
    end

    // ------------------------------------------------------------------
    // Data bits per character
    // ------------------------------------------------------------------
    // five to eight bits
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dataBits <= 4'h5;
        end else begin
            dataBits <= 4'h5 + {2'h0, uart_mode_first[`UMC_BPC_HI:`UMC_BPC_LO]};
        end
    end

    // ------------------------------------------------------------------
    // Parity generation
    // ------------------------------------------------------------------
    assign pmode = umc_pmode_t'(uart_mode_first[`UMC_PM_HI:`UMC_PM_LO]);
    assign ptype = uart_mode_first[`UMC_BIT_PTYPE];
    // Unused high bits masked so short characters parity correctly
    assign maskedData = txData & (8'hff >> (4'h8 - dataBits));
    assign evenPar    = ^maskedData;

    always_comb begin
        next_parEn  = 1'b1;
        next_parBit = 1'b0;
        case (pmode)
            UMC_PM_WITH: begin
                next_parBit = ptype ? ~evenPar : evenPar;
            end
            UMC_PM_FORCE: begin
                next_parBit = ptype;
            end
            UMC_PM_NONE: begin
                next_parEn = 1'b0;
            end
            UMC_PM_MDROP: begin
                next_parBit = ptype;
            end
            default: begin
                next_parEn = 1'b0;
            end
        endcase
    end

    // registered transmit parity and receive check enable
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            txParityEn  <= 1'b0;
            txParityBit <= 1'b0;
            rxParityChk <= 1'b0;
        end else begin
            txParityEn  <= next_parEn;
            txParityBit <= next_parBit;
            // Multidrop uses the slot as a flag, so no check there
            rxParityChk <= (pmode == UMC_PM_WITH) || (pmode == UMC_PM_FORCE);
        end
    end

    // ------------------------------------------------------------------
    // Flow control and error accumulation
    // ------------------------------------------------------------------
    // Transmit bit of the second register feeds the cancel case
    // RTS handling
    umc_rts_ctrl uRts (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .rxFlowEn      (uart_mode_first[`UMC_BIT_RXFLOW]),
        .txFlowEn      (modeSecond[`UMC_BIT_TXFLOW]),
        .startBitValid (startBitValid),
        .fifoFull      (rxFifoFull),
        .rtsNegate     (rtsNegate)
    );

    // error flag mode; left to software
    umc_err_status uErr (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .blockMode (uart_mode_first[`UMC_BIT_ERRMODE]),
        .resetErr  (resetErr),
        .topValid  (topValid),
        .topPop    (topPop),
        .topErr    (topErr),
        .errFlags  (errFlags)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_PTR_ADV: assert property (@(posedge ref_clk) disable iff (!rst_b)
        modePtr == UMC_PTR_FIRST && modeAccess && !resetPtr |=> modePtr == UMC_PTR_SECOND)
        else $error("pointer did not advance");
    AST_PTR_RST: assert property (@(posedge ref_clk) disable iff (!rst_b)
        resetPtr |=> modePtr == UMC_PTR_FIRST)
        else $error("pointer not reset by command");
    AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        modePtr == UMC_PTR_SECOND && !resetPtr |=> modePtr == UMC_PTR_SECOND)
        else $error("pointer left second register");
    AST_WR_GATE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        modePtr == UMC_PTR_SECOND |=> uart_mode_first == $past(uart_mode_first))
        else $error("first register written while not selected");
    AST_IRQ_SRC: assert property (@(posedge ref_clk) disable iff (!rst_b)
        uart_mode_first[`UMC_BIT_IRQSEL] && $stable(uart_mode_first)
        |=> rxIrqSrc == $past(rxFifoFull))
        else $error("interrupt source not fifo full");
    AST_BITS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        uart_mode_first[1:0] == 2'h3 |=> dataBits == 4'h8)
        else $error("wrong data bit count");
    AST_PAR_NONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_NONE |=> !txParityEn)
        else $error("parity sent in no-parity mode");
    AST_PAR_MDROP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_MDROP |=> txParityEn && txParityBit == $past(ptype))
        else $error("multidrop flag wrong");

    // ------------------------------------------------------------------
    // Register access checks
    // ------------------------------------------------------------------
    AST_WR_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWr && modeAccess && modePtr == UMC_PTR_FIRST
        |=> uart_mode_first == $past(regWdata))
        else $error("first register write did not land");
    AST_RD_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRd && modeAccess && modePtr == UMC_PTR_FIRST
        |=> regRdata == $past(uart_mode_first))
        else $error("first register read returned wrong data");
    AST_WR_SECOND: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWr && modeAccess && modePtr == UMC_PTR_SECOND
        |=> modeSecond == $past(regWdata))
        else $error("second register write did not land");
    AST_RD_SECOND: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRd && !regWr && modeAccess && modePtr == UMC_PTR_SECOND
        |=> regRdata == $past(modeSecond))
        else $error("second register read returned wrong data");

    // ------------------------------------------------------------------
    // Derived control checks
    // ------------------------------------------------------------------
    AST_IRQ_READY: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !uart_mode_first[`UMC_BIT_IRQSEL] |=> rxIrqSrc == $past(rxCharAvail))
        else $error("interrupt source not receiver ready");
    AST_BITS_FIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        uart_mode_first[`UMC_BPC_HI:`UMC_BPC_LO] == 2'h0 |=> dataBits == 4'h5)
        else $error("wrong short data bit count");
    AST_PAR_FORCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_FORCE |=> txParityEn && txParityBit == $past(ptype))
        else $error("forced parity level wrong");
    AST_PAR_WITH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_WITH |=> txParityEn && rxParityChk)
        else $error("parity not generated and checked");
    AST_RX_NOCHK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_NONE |=> !rxParityChk)
        else $error("parity checked in no-parity mode");

    COV_PTR_CYCLE: cover property (@(posedge ref_clk) disable iff (!rst_b)
        modePtr == UMC_PTR_SECOND ##1 resetPtr ##1 modePtr == UMC_PTR_FIRST);
    COV_ODD: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_WITH && ptype);
    COV_MDROP: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pmode == UMC_PM_MDROP);
endmodule : umc_mode_one

`default_nettype wire

//--- umc_remote_tx.sv
// Remote serial transmitter model that watches receiver flow control
`default_nettype none

module umc_remote_tx (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Flow control seen at the far end, request from the bench
    input  wire logic rtsNegate,
    input  wire logic sendReq,
    // Start of a character as the receiver sees it
    output logic      startBitValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Character start
    // ------------------------------------------------------------------
    // hold while negated
    // A start is refused while RTS is negated, as a real sender would do
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            startBitValid <= 1'b0;
        end else begin
            startBitValid <= sendReq && !rtsNegate && !startBitValid;
        end
    end
endmodule : umc_remote_tx

`default_nettype wire

//--- umc_mode_one_tb.sv
// Self-checking bench for the first mode register block
`default_nettype none
`include "umc_consts.svh"

module umc_mode_one_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import umc_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk;
    logic        rst_b;
    logic [3:0]  regAddr;
    logic        regRd;
    logic        regWr;
    logic [7:0]  regWdata;
    logic [7:0]  regRdata;
    logic        rxCharAvail;
    logic        rxFifoFull;
    logic        startBitValid;
    logic        sendReq;
    logic        topValid;
    logic        topPop;
    logic [2:0]  topErr;
    logic [7:0]  txData;
    logic        rxIrqSrc;
    logic        rtsNegate;
    logic [2:0]  errFlags;
    logic        txParityEn;
    logic        txParityBit;
    logic [3:0]  dataBits;
    logic        rxParityChk;
    logic [7:0]  modeSecond;
    umc_ptr_t    modePtr;
    int          num_errors;
    int          checks_done;

    localparam logic [7:0] CMD_PTR = {1'b0, `UMC_CMD_RSTPTR, 4'h0};
    localparam logic [7:0] CMD_ERR = {1'b0, `UMC_CMD_RSTERR, 4'h0};

    umc_mode_one dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regRd(regRd),
        .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
        .rxCharAvail(rxCharAvail), .rxFifoFull(rxFifoFull),
        .startBitValid(startBitValid), .topValid(topValid), .topPop(topPop),
        .topErr(topErr), .txData(txData), .rxIrqSrc(rxIrqSrc),
        .rtsNegate(rtsNegate), .errFlags(errFlags), .txParityEn(txParityEn),
        .txParityBit(txParityBit), .dataBits(dataBits),
        .rxParityChk(rxParityChk), .modeSecond(modeSecond), .modePtr(modePtr)
    );

    umc_remote_tx far (
        .ref_clk(ref_clk), .rst_b(rst_b), .rtsNegate(rtsNegate),
        .sendReq(sendReq), .startBitValid(startBitValid)
    );

    // Free-running 50 MHz clock
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Inputs always move 2 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : tick

    // One byte access, then one idle edge so read data has landed
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        regAddr  = a;
        regWdata = d;
        regWr    = wr;
        regRd    = !wr;
        tick(1);
        regWr = 1'b0;
        regRd = 1'b0;
        tick(1);
    endtask : bus

    // Point back at the first register and load it
    // only while link idle
    task automatic set_first(input logic [7:0] v);
        bus(1'b1, `UMC_OFS_COMMAND, CMD_PTR);
        bus(1'b1, `UMC_OFS_MODE, v);
        tick(1);
    endtask : set_first

    task automatic send;
        sendReq = 1'b1;
        tick(1);
        sendReq = 1'b0;
        tick(3);
    endtask : send

    task automatic pop(input logic [2:0] e);
        topErr = e;
        topPop = 1'b1;
        tick(1);
        topPop = 1'b0;
        tick(2);
    endtask : pop

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // pointer walk
    task automatic t_pointer;
        check(8'(modePtr), 8'(UMC_PTR_FIRST));
        check(8'(dataBits), 8'h05);
        bus(1'b1, `UMC_OFS_MODE, 8'h5a);
        check(8'(modePtr), 8'(UMC_PTR_SECOND));
        bus(1'b1, `UMC_OFS_MODE, 8'h20);
        check(modeSecond, 8'h20);
        bus(1'b0, `UMC_OFS_MODE, 8'h00);
        check(regRdata, 8'h20);
        check(8'(modePtr), 8'(UMC_PTR_SECOND));
        bus(1'b1, `UMC_OFS_COMMAND, CMD_PTR);
        check(8'(modePtr), 8'(UMC_PTR_FIRST));
        bus(1'b0, `UMC_OFS_MODE, 8'h00);
        check(regRdata, 8'h5a);
        check(8'(modePtr), 8'(UMC_PTR_SECOND));
    endtask : t_pointer

    task automatic t_length;
        for (int i = 0; i < 4; i++) begin
            set_first(8'(i));
            check(8'(dataBits), 8'(5 + i));
        end
    endtask : t_length

    task automatic t_parity;
        logic [1:0] pm;
        logic       pt;
        // Low five bits hold three ones, the whole byte six
        txData = 8'hf3;
        for (int i = 0; i < 8; i++) begin
            pm = 2'(i >> 1);
            pt = i[0];
            set_first({3'h0, pm, pt, 2'h0});
            check(8'(txParityEn), 8'(pm != 2'h2));
            if (pm != 2'h2) check(8'(txParityBit), 8'(pm == 2'h0 ? !pt : pt));
            if (pm[0] == 1'b0) check(8'(rxParityChk), 8'(pm == 2'h0));
        end
    endtask : t_parity

    task automatic t_irq;
        rxCharAvail = 1'b1;
        set_first(8'h00);
        check(8'(rxIrqSrc), 8'h01);
        set_first(8'h40);
        check(8'(rxIrqSrc), 8'h00);
        rxFifoFull = 1'b1;
        tick(2);
        check(8'(rxIrqSrc), 8'h01);
        rxFifoFull  = 1'b0;
        rxCharAvail = 1'b0;
    endtask : t_irq

    task automatic t_rts;
        set_first(8'h80);
        rxFifoFull = 1'b1;
        send();
        check(8'(rtsNegate), 8'h00);
        bus(1'b1, `UMC_OFS_MODE, 8'h00);
        tick(1);
        send();
        check(8'(rtsNegate), 8'h01);
        rxFifoFull = 1'b0;
        tick(2);
        check(8'(rtsNegate), 8'h00);
        set_first(8'h00);
        rxFifoFull = 1'b1;
        send();
        check(8'(rtsNegate), 8'h00);
        rxFifoFull = 1'b0;
    endtask : t_rts

    task automatic t_err;
        topValid = 1'b1;
        set_first(8'h00);
        pop(3'h4);
        check(8'(errFlags), 8'h04);
        pop(3'h1);
        check(8'(errFlags), 8'h01);
        topValid = 1'b0;
        tick(2);
        check(8'(errFlags), 8'h00);
        topValid = 1'b1;
        set_first(8'h20);
        pop(3'h4);
        pop(3'h1);
        check(8'(errFlags), 8'h05);
        pop(3'h0);
        bus(1'b1, `UMC_OFS_COMMAND, CMD_ERR);
        tick(1);
        check(8'(errFlags), 8'h00);
        pop(3'h2);
        check(8'(errFlags), 8'h02);
    endtask : t_err

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Watchdog well beyond the 150 or so cycles the run needs
    initial begin
        #(20 * 4000);
        num_errors++;
        end_of_test();
    end

    initial begin
        num_errors  = 0;
        checks_done = 0;
        rst_b       = 1'b0;
        regAddr     = 4'h0;
        regRd       = 1'b0;
        regWr       = 1'b0;
        regWdata    = 8'h00;
        rxCharAvail = 1'b0;
        rxFifoFull  = 1'b0;
        sendReq     = 1'b0;
        topValid    = 1'b0;
        topPop      = 1'b0;
        topErr      = 3'h0;
        txData      = 8'h00;
        tick(5);
        rst_b = 1'b1;
        t_pointer();
        t_length();
        t_parity();
        t_irq();
        t_rts();
        t_err();
        end_of_test();
    end
endmodule : umc_mode_one_tb

`default_nettype wire
